// ==== tc_defs.svh ====
// Register offsets, field positions and reset values of the timer/counter.
// Assumes a 12-bit APB byte address; every register is one aligned word.
`ifndef TC_DEFS_SVH
`define TC_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TC_OFF_COUNT_LOW    12'h000
`define TC_OFF_COUNT_HIGH   12'h004
`define TC_OFF_CTRL_A       12'h008
`define TC_OFF_CTRL_B       12'h00C
`define TC_OFF_EVENT_STAT   12'h010

// ****************************************************************
// Field positions
// ****************************************************************
`define TC_A_EN_BIT         7
`define TC_A_OUT_BIT        5
`define TC_A_WIDE_BIT       4
`define TC_A_OUTPS_LSB      0
`define TC_B_CS_LSB         5
`define TC_B_ASYNC_BIT      4
`define TC_B_CKPS_LSB       0
`define TC_S_FLAG_BIT       0
`define TC_S_IE_BIT         1

// ****************************************************************
// Reset values
// ****************************************************************
`define TC_RST_COUNT_LOW    8'h00
`define TC_RST_PERIOD       8'hFF
`define TC_ALL_ONES_16      16'hFFFF

`endif

// ==== tc_pkg.sv ====
// Types shared by the timer/counter and its prescaler.
// Assumes a 12-bit APB address and 32-bit data.
package tc_pkg;

    // ****************************************************************
    // Bus carriers
    // ****************************************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_t;

    // ****************************************************************
    // Clock source codes
    // ****************************************************************
    typedef enum logic [2:0] {
        CS_PIN_TRUE  = 3'b000,
        CS_PIN_INV   = 3'b001,
        CS_INSTR     = 3'b010,
        CS_HF_OSC    = 3'b011,
        CS_LF_OSC    = 3'b100,
        CS_RESERVED  = 3'b101,
        CS_SEC_OSC   = 3'b110,
        CS_LOGIC_ONE = 3'b111
    } clk_src_t;

    // ****************************************************************
    // Control fields and module state
    // ****************************************************************
    typedef struct packed {
        logic       en;
        logic       wide;
        logic [3:0] outps;
    } ctrl_a_t;

    typedef struct packed {
        clk_src_t   cs;
        logic       async_sel;
        logic [3:0] ckps;
    } ctrl_b_t;

    typedef struct packed {
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [7:0]  hp;
        logic [7:0]  pbuf;
        logic [7:0]  snap_hi;
        logic [3:0]  post;
        logic        tout;
        logic        pulse;
        logic        flag;
        logic        ie;
        ctrl_a_t     ctrl_a;
        ctrl_b_t     ctrl_b;
        logic        sync1;
        logic        sync2;
        logic        sync3;
        logic        raw_prev;
        logic [31:0] prdata;
    } tc_state_t;

    typedef struct packed {
        logic [14:0] cnt;
    } pre_state_t;

endpackage

// ==== tc_prescaler.sv ====
// Power-of-two prescaler for the timer/counter.
// Assumes one-cycle input ticks on sys_clk; clear has priority over counting.
`timescale 1ns/1ns

module tc_prescaler #(
    parameter int PRE_W = 15,
    parameter int SEL_W = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             tick_in,
    input  wire logic             clear,
    input  wire logic [SEL_W-1:0] sel,
    output logic                  tick_out,
    output logic [PRE_W-1:0]      pre_count
);

    // ****************************************************************
    // Ratio decode
    // ****************************************************************
    // Low n bits all ones marks every 2^n-th tick
    function automatic logic [PRE_W-1:0] ratio_mask(input logic [SEL_W-1:0] s);
        ratio_mask = PRE_W'((32'h1 << s) - 32'h1);
    endfunction

    tc_pkg::pre_state_t st;
    tc_pkg::pre_state_t next_st;
    logic [PRE_W-1:0]   mask;

    // Output tick and next count
    always_comb begin
        mask     = ratio_mask(sel);
        next_st  = st;
        tick_out = tick_in && !clear && ((st.cnt & mask) == mask);
        if (clear) begin
            next_st.cnt = '0;
        end else if (tick_in) begin
            next_st.cnt = st.cnt + PRE_W'(1);
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= '{cnt: '0};
        end else begin
            st <= next_st;
        end
    end

    assign pre_count = st.cnt;

endmodule

// ==== timer_counter.sv ====
// 8/16-bit timer/counter with prescaler, postscaler and APB registers.
// Assumes all clock source inputs are sampled on sys_clk; sys_clk is the
// instruction clock and sleep_mode is a level from the power controller.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "tc_defs.svh"

// Operation
// - wide_count_select picks 8-bit or 16-bit count
// - Instruction clock every cycle, else rising edges
// - Fifteen-bit prescaler, sixteen power-of-two ratios
// - Low byte read copies true high byte
// - Low byte write loads high from buffer
// - Eight-bit match clears count, reloads buffer, feeds postscaler
// - Eight-bit registers direct; reset count 0, period FF
// - Low byte and control writes, disable and reset clear prescaler and postscaler
// - Prescale code zero counts every input edge
// - Asynchronous select counts raw edges, even sleeping
// - Synchronous select resynchronises the counter clock
// - Synchronous and instruction clock halt in sleep; asynchronous keeps counting
// - Three-bit field chooses the clock source
// - Postscaler divides events by one to sixteen
// - Base event is match or 16-bit rollover
// - Flag sets every postscale-plus-one events
// - Enabled flag raises the interrupt request
// - Output toggles every postscale-plus-one events
// - Output readable as status and exported
// - Prescaler and postscaler not software visible
// - Source codes map pin, oscillators, logic cell
// - Enable bit runs module; clear stops it
// - Prescale code n divides by two to n
module timer_counter (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire tc_pkg::apb_req_t apb_req,
    output tc_pkg::apb_rsp_t      apb_rsp,
    input  wire logic             clk_in_pin,
    input  wire logic             hf_osc,
    input  wire logic             lf_osc,
    input  wire logic             sec_osc,
    input  wire logic             logic_cell,
    input  wire logic             sleep_mode,
    output logic                  timer_output_status,
    output logic                  timer_output_pulse,
    output logic                  timer_irq
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    typedef enum logic [2:0] {
        R_LOW  = 3'b000,
        R_HIGH = 3'b001,
        R_CA   = 3'b010,
        R_CB   = 3'b011,
        R_STAT = 3'b100,
        R_NONE = 3'b111
    } reg_sel_t;

    // Maps a byte address onto a register; prescaler state has no address
    function automatic reg_sel_t decode(input logic [11:0] a);
        unique case (a)
            `TC_OFF_COUNT_LOW:  decode = R_LOW;
            `TC_OFF_COUNT_HIGH: decode = R_HIGH;
            `TC_OFF_CTRL_A:     decode = R_CA;
            `TC_OFF_CTRL_B:     decode = R_CB;
            `TC_OFF_EVENT_STAT: decode = R_STAT;
            default:            decode = R_NONE;
        endcase
    endfunction

    localparam tc_pkg::tc_state_t ST_RESET = '{
        lo:     `TC_RST_COUNT_LOW,
        hp:     `TC_RST_PERIOD,
        pbuf:   `TC_RST_PERIOD,
        ctrl_a: '{en: 1'b0, wide: 1'b0, outps: 4'h0},
        ctrl_b: '{cs: tc_pkg::CS_PIN_TRUE, async_sel: 1'b0, ckps: 4'h0},
        default: '0
    };

    tc_pkg::tc_state_t st;
    tc_pkg::tc_state_t next_st;
    reg_sel_t          rsel;
    logic              setup_rd;
    logic              acc;
    logic              wr;
    logic              rd_low;
    logic              wr_low;
    logic              wr_ctrl;
    logic              wr_stat;
    logic              pre_clear;
    logic              src_raw;
    logic              edge_sync;
    logic              edge_raw;
    logic              src_tick;
    logic              ptick;
    logic              base_event;
    logic              post_event;
    logic [15:0]       full;
    logic [15:0]       full_inc;
    logic [31:0]       rdata;
    logic [14:0]       pre_count;

    // ****************************************************************
    // Bus strobes and clock source
    // ****************************************************************
    // Access completes in its first access cycle
    always_comb begin
        rsel     = decode(apb_req.paddr);
        setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
        acc      = apb_req.psel && apb_req.penable;
        wr       = acc && apb_req.pwrite;
        rd_low   = acc && !apb_req.pwrite && (rsel == R_LOW);
        wr_low   = wr && (rsel == R_LOW);
        wr_ctrl  = wr && ((rsel == R_CA) || (rsel == R_CB));
        wr_stat  = wr && (rsel == R_STAT);
        pre_clear = wr_low || wr_ctrl || !st.ctrl_a.en;
    end

    // Source multiplexer
    always_comb begin
        unique case (st.ctrl_b.cs)
            tc_pkg::CS_PIN_TRUE:  src_raw = clk_in_pin;
            tc_pkg::CS_PIN_INV:   src_raw = !clk_in_pin;
            tc_pkg::CS_INSTR:     src_raw = 1'b1;
            tc_pkg::CS_HF_OSC:    src_raw = hf_osc;
            tc_pkg::CS_LF_OSC:    src_raw = lf_osc;
            tc_pkg::CS_RESERVED:  src_raw = 1'b0;
            tc_pkg::CS_SEC_OSC:   src_raw = sec_osc;
            tc_pkg::CS_LOGIC_ONE: src_raw = logic_cell;
        endcase
    end

    // Edge detection; sync path reads only the second stage onward
    always_comb begin
        edge_sync = st.sync2 && !st.sync3;
        edge_raw  = src_raw && !st.raw_prev;
        if (st.ctrl_b.cs == tc_pkg::CS_INSTR) begin
            src_tick = !sleep_mode;
        end else if (st.ctrl_b.async_sel) begin
            src_tick = edge_raw;
        end else begin
            src_tick = edge_sync && !sleep_mode;
        end
    end

    tc_prescaler #(
        .PRE_W (15),
        .SEL_W (4)
    ) u_prescaler (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .tick_in   (src_tick && st.ctrl_a.en),
        .clear     (pre_clear),
        .sel       (st.ctrl_b.ckps),
        .tick_out  (ptick),
        .pre_count (pre_count)
    );

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Register image seen by a read
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (rsel)
            R_LOW:  rdata[7:0] = st.lo;
            R_HIGH: rdata[7:0] = st.hp;
            R_CA: begin
                rdata[`TC_A_EN_BIT]          = st.ctrl_a.en;
                rdata[`TC_A_OUT_BIT]         = st.tout;
                rdata[`TC_A_WIDE_BIT]        = st.ctrl_a.wide;
                rdata[`TC_A_OUTPS_LSB +: 4]  = st.ctrl_a.outps;
            end
            R_CB: begin
                rdata[`TC_B_CS_LSB +: 3]     = st.ctrl_b.cs;
                rdata[`TC_B_ASYNC_BIT]       = st.ctrl_b.async_sel;
                rdata[`TC_B_CKPS_LSB +: 4]   = st.ctrl_b.ckps;
            end
            R_STAT: begin
                rdata[`TC_S_FLAG_BIT]        = st.flag;
                rdata[`TC_S_IE_BIT]          = st.ie;
            end
            R_NONE: rdata = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Counter, postscaler and registers
    // ****************************************************************
    // Next state: count, events, then bus writes on top
    always_comb begin
        next_st    = st;
        full       = {st.hi, st.lo};
        full_inc   = full + 16'h0001;
        base_event = 1'b0;
        post_event = 1'b0;
        next_st.sync1    = src_raw;
        next_st.sync2    = st.sync1;
        next_st.sync3    = st.sync2;
        next_st.raw_prev = src_raw;
        if (setup_rd) begin
            next_st.prdata  = rdata;
            next_st.snap_hi = st.hi;
        end
        if (ptick) begin
            next_st.pulse = 1'b0;
            if (st.ctrl_a.wide) begin
                next_st.hi = full_inc[15:8];
                next_st.lo = full_inc[7:0];
                base_event = (full == `TC_ALL_ONES_16);
            end else if (st.lo == st.pbuf) begin
                next_st.lo   = 8'h00;
                next_st.pbuf = st.hp;
                base_event   = 1'b1;
            end else begin
                next_st.lo = st.lo + 8'h01;
            end
        end
        if (base_event) begin
            post_event = (st.post == st.ctrl_a.outps);
            next_st.post = post_event ? 4'h0 : st.post + 4'h1;
        end
        if (post_event) begin
            next_st.tout  = !st.tout;
            next_st.pulse = 1'b1;
        end
        if (pre_clear) begin
            next_st.post = 4'h0;
        end
        if (rd_low && st.ctrl_a.wide) begin
            next_st.hp = st.snap_hi;
        end
        if (wr) begin
            unique case (rsel)
                R_LOW: begin
                    next_st.lo = apb_req.pwdata[7:0];
                    if (st.ctrl_a.wide) begin
                        next_st.hi = st.hp;
                    end
                end
                R_HIGH: next_st.hp = apb_req.pwdata[7:0];
                R_CA: begin
                    next_st.ctrl_a.en    = apb_req.pwdata[`TC_A_EN_BIT];
                    next_st.ctrl_a.wide  = apb_req.pwdata[`TC_A_WIDE_BIT];
                    next_st.ctrl_a.outps = apb_req.pwdata[`TC_A_OUTPS_LSB +: 4];
                end
                R_CB: begin
                    next_st.ctrl_b.cs =
                        tc_pkg::clk_src_t'(apb_req.pwdata[`TC_B_CS_LSB +: 3]);
                    next_st.ctrl_b.async_sel = apb_req.pwdata[`TC_B_ASYNC_BIT];
                    next_st.ctrl_b.ckps      = apb_req.pwdata[`TC_B_CKPS_LSB +: 4];
                end
                R_STAT: next_st.ie = apb_req.pwdata[`TC_S_IE_BIT];
                R_NONE: next_st.ie = st.ie;
            endcase
        end
        // Write-one clears the flag; a new event in that cycle wins
        if (wr_stat && apb_req.pwdata[`TC_S_FLAG_BIT]) begin
            next_st.flag = 1'b0;
        end
        if (post_event) begin
            next_st.flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign apb_rsp.pready      = 1'b1;
    assign apb_rsp.prdata      = st.prdata;
    assign apb_rsp.pslverr     = acc && (rsel == R_NONE);
    assign timer_output_status = st.tout;
    assign timer_output_pulse  = st.pulse;
    assign timer_irq           = st.flag && st.ie;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    AST_WIDE_WRAP: assert property (
        ptick && st.ctrl_a.wide && full == 16'hFFFF
        |-> base_event ##1 ({st.hi, st.lo} == 16'h0000))
        else $error("16-bit count did not wrap with an event");

    AST_NARROW_MATCH: assert property (
        ptick && !st.ctrl_a.wide && st.lo == st.pbuf
        |=> st.lo == 8'h00 && st.pbuf == $past(st.hp))
        else $error("8-bit match did not clear count and reload buffer");

    AST_READ_SNAP: assert property (
        rd_low && st.ctrl_a.wide |=> st.hp == $past(st.hi, 2))
        else $error("low byte read did not copy the high byte");

    AST_WRITE_LOAD: assert property (
        wr_low && st.ctrl_a.wide
        |=> st.hi == $past(st.hp) && st.lo == $past(apb_req.pwdata[7:0]))
        else $error("low byte write did not load all 16 bits");

    AST_PRE_CLEAR: assert property (
        wr_low || wr_ctrl |=> pre_count == 15'h0000 && st.post == 4'h0)
        else $error("scaler counters not cleared by write");

    AST_POST_COUNT: assert property (
        base_event && st.post != st.ctrl_a.outps && !pre_clear
        |=> st.post == $past(st.post) + 4'h1)
        else $error("postscaler did not advance");

    AST_FLAG_SET: assert property (
        base_event && st.post == st.ctrl_a.outps |=> st.flag ##0 st.tout != $past(st.tout))
        else $error("flag or output missed a postscaled event");

    AST_FLAG_HOLD: assert property (
        st.flag && !(wr_stat && apb_req.pwdata[0]) |=> st.flag)
        else $error("flag dropped without software clear");

    AST_DISABLED: assert property (
        !st.ctrl_a.en && !wr |=> $stable({st.hi, st.lo}))
        else $error("count moved while disabled");

    AST_SLEEP_HALT: assert property (
        sleep_mode && !st.ctrl_b.async_sel && !wr |=> $stable({st.hi, st.lo}))
        else $error("synchronous count moved during sleep");

    AST_IRQ_FOLLOWS: assert property (
        post_event && st.ie && !wr_stat |=> timer_irq [*2])
        else $error("interrupt request not raised for enabled flag");

    COV_WIDE_WRAP: cover property (ptick && st.ctrl_a.wide && full == 16'hFFFF);
    COV_NARROW_MATCH: cover property (ptick && !st.ctrl_a.wide && st.lo == st.pbuf);
    COV_POSTSCALED: cover property (post_event && st.ctrl_a.outps != 4'h0);
    COV_ASYNC_SLEEP: cover property (sleep_mode && st.ctrl_b.async_sel && ptick);

endmodule

// ==== tb.sv ====
// Self-checking testbench for the 8/16-bit timer/counter.
// Assumes the APB slave answers with pready high and sources are sampled on sys_clk.
`timescale 1ns/1ns
`include "tc_defs.svh"

module tb;
    logic              sys_clk;
    logic              srst;
    tc_pkg::apb_req_t  req;
    tc_pkg::apb_rsp_t  rsp;
    logic [3:0]        div;
    logic              sleep_mode;
    logic              tos;
    logic              tpulse;
    logic              tirq;
    logic              last_err;
    logic [31:0]       r;
    logic [31:0]       r2;
    int                n_errors;
    int                checks;
    int                cs_exp [8] = '{16, 16, 0, 8, 32, 0, 32, 4};

    timer_counter timer_counter_inst (
        .sys_clk             (sys_clk),
        .srst                (srst),
        .apb_req             (req),
        .apb_rsp             (rsp),
        .clk_in_pin          (div[2]),
        .hf_osc              (div[1]),
        .lf_osc              (div[3]),
        .sec_osc             (~div[3]),
        .logic_cell          (div[0]),
        .sleep_mode          (sleep_mode),
        .timer_output_status (tos),
        .timer_output_pulse  (tpulse),
        .timer_irq           (tirq)
    );

    // ****************************************************************
    // Clock and source dividers
    // ****************************************************************
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    // Free divider feeding every external clock source
    always @(posedge sys_clk) begin
        div <= div + 4'h1;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic final_report();
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do begin
            @(posedge sys_clk);
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        last_err = rsp.pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    // Cycles between two output toggles, after one toggle to settle
    task automatic meas(input int exp);
        int n;
        logic s;
        for (int k = 0; k < 2; k++) begin
            s = tos;
            n = 0;
            while (tos === s && n < 5000) begin
                @(posedge sys_clk);
                n++;
            end
        end
        chk(n, exp);
    endtask

    // Width of one output pulse in cycles
    task automatic pulse_len(input int exp);
        int n;
        n = 0;
        while (tpulse !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
        n = 0;
        while (tpulse === 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        chk(n, exp);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        srst = 1'b1;
        req = '0;
        div = 4'h0;
        sleep_mode = 1'b0;
        n_errors = 0;
        checks = 0;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        // Reset values and unmapped access
        rd_chk(`TC_OFF_COUNT_LOW, 32'h00);
        rd_chk(`TC_OFF_COUNT_HIGH, 32'hFF);
        rd_chk(`TC_OFF_CTRL_A, 32'h00);
        rd_chk(`TC_OFF_CTRL_B, 32'h00);
        rd_chk(`TC_OFF_EVENT_STAT, 32'h00);
        rd_chk(12'h014, 32'h00);
        chk(last_err, 1'b1);
        // Output status bit ignores writes and reads 0 before any toggle
        wr(`TC_OFF_CTRL_A, 32'h20);
        rd_chk(`TC_OFF_CTRL_A, 32'h00);
        chk(last_err, 1'b0);
        // Eight-bit mode on the instruction clock, period 3
        wr(`TC_OFF_COUNT_HIGH, 32'h03);
        wr(`TC_OFF_CTRL_B, 32'h40);
        wr(`TC_OFF_CTRL_A, 32'h80);
        meas(4);
        pulse_len(1);
        wr(`TC_OFF_CTRL_A, 32'h82);
        meas(12);
        wr(`TC_OFF_CTRL_A, 32'h80);
        wr(`TC_OFF_CTRL_B, 32'h42);
        meas(16);
        pulse_len(4);
        // Flag, enable and write-one-to-clear
        wr(`TC_OFF_CTRL_B, 32'h40);
        wr(`TC_OFF_CTRL_A, 32'h81);
        wr(`TC_OFF_EVENT_STAT, 32'h01);
        repeat (20) @(posedge sys_clk);
        chk(tirq, 1'b0);
        rd_chk(`TC_OFF_EVENT_STAT, 32'h01);
        wr(`TC_OFF_EVENT_STAT, 32'h02);
        repeat (20) @(posedge sys_clk);
        chk(tirq, 1'b1);
        wr(`TC_OFF_CTRL_A, 32'h00);
        wr(`TC_OFF_EVENT_STAT, 32'h03);
        rd_chk(`TC_OFF_EVENT_STAT, 32'h02);
        chk(tirq, 1'b0);
        // Output status bit is read-only and mirrors the output
        wr(`TC_OFF_CTRL_A, 32'h20);
        apb(1'b0, `TC_OFF_CTRL_A, 32'h0, r);
        chk(r, {26'h0, tos, 5'h0});
        // Instruction-clock counting halts in sleep
        wr(`TC_OFF_CTRL_A, 32'h80);
        sleep_mode <= 1'b1;
        apb(1'b0, `TC_OFF_COUNT_LOW, 32'h0, r);
        repeat (10) @(posedge sys_clk);
        apb(1'b0, `TC_OFF_COUNT_LOW, 32'h0, r2);
        chk(r2, r);
        sleep_mode <= 1'b0;
        // Every clock source except the instruction clock, synchronous, period 1
        wr(`TC_OFF_COUNT_HIGH, 32'h01);
        for (int c = 0; c < 8; c++) begin
            if (c != 2) begin
                wr(`TC_OFF_CTRL_B, {24'h0, c[2:0], 5'h00});
                if (cs_exp[c] == 0) begin
                    // Let the synchroniser flush the previous source
                    repeat (4) @(posedge sys_clk);
                    apb(1'b0, `TC_OFF_COUNT_LOW, 32'h0, r);
                    repeat (40) @(posedge sys_clk);
                    apb(1'b0, `TC_OFF_COUNT_LOW, 32'h0, r2);
                    chk(r2, r);
                end else begin
                    meas(cs_exp[c]);
                end
            end
        end
        // Asynchronous pin counting goes on in sleep
        wr(`TC_OFF_CTRL_B, 32'h10);
        sleep_mode <= 1'b1;
        meas(16);
        sleep_mode <= 1'b0;
        // Sixteen-bit buffered access
        wr(`TC_OFF_CTRL_B, 32'h40);
        wr(`TC_OFF_CTRL_A, 32'h10);
        wr(`TC_OFF_COUNT_HIGH, 32'h12);
        wr(`TC_OFF_COUNT_LOW, 32'h34);
        wr(`TC_OFF_COUNT_HIGH, 32'h56);
        rd_chk(`TC_OFF_COUNT_LOW, 32'h34);
        rd_chk(`TC_OFF_COUNT_HIGH, 32'h12);
        // Rollover from all ones sets the flag and keeps counting
        wr(`TC_OFF_COUNT_HIGH, 32'hFF);
        wr(`TC_OFF_COUNT_LOW, 32'hFC);
        wr(`TC_OFF_EVENT_STAT, 32'h01);
        wr(`TC_OFF_CTRL_A, 32'h90);
        repeat (20) @(posedge sys_clk);
        wr(`TC_OFF_CTRL_A, 32'h10);
        rd_chk(`TC_OFF_EVENT_STAT, 32'h01);
        apb(1'b0, `TC_OFF_COUNT_LOW, 32'h0, r);
        chk({31'h0, r < 32'h30}, 32'h1);
        rd_chk(`TC_OFF_COUNT_HIGH, 32'h00);
        // Mid-run reset restores count and period
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        rd_chk(`TC_OFF_COUNT_LOW, 32'h00);
        rd_chk(`TC_OFF_COUNT_HIGH, 32'hFF);
        final_report();
    end

    // Watchdog against a hung wait
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        final_report();
    end
endmodule
